// ===== crcc_top.sv
// crc engine control, configuration and serial shifter
`timescale 1ns/100ps
module crcc_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // status
  output logic busy,
  output logic full
);
  // control fields
  logic module_enable; // engine out of reset
  logic shifter_start; // serial shifter running
  logic augment_mode; // data augmented with zeros
  logic shift_direction; // 1 shifts right, 0 left
  logic [3:0] data_word_length; // bits per word minus one
  logic [3:0] poly_length; // polynomial width minus one

  // data path registers
  logic [7:0] input_data_high; // upper byte of next word
  logic [7:0] input_data_low; // lower byte of last word
  logic [15:0] poly; // polynomial, top term implied
  logic [15:0] acc; // crc accumulator
  logic [15:0] shifter; // word being shifted in
  logic [4:0] bits_left; // bits of current word not yet used

  // engine helpers
  logic in_bit; // bit leaving the shifter
  logic feedback; // polynomial subtract this step
  logic step; // one bit enters the accumulator
  logic load; // fifo word moves into the shifter
  logic [15:0] len_mask; // keeps acc within poly width
  logic [15:0] next_acc; // accumulator after one step
  logic [15:0] next_shifter; // shifter after one step

  // register decode strobes
  logic wr_ctrl;
  logic wr_len;
  logic wr_dhi;
  logic wr_dlo;
  logic wr_ahi;
  logic wr_alo;
  logic wr_phi;
  logic wr_plo;

  // channel from register port into the fifo
  crcc_word_if #(.W(crcc_pkg::WORD_W)) push_if ();
  // channel from fifo into the shifter
  crcc_word_if #(.W(crcc_pkg::WORD_W)) pop_if ();

  // write decode, one strobe per writable register; the shifter bytes have none
  assign wr_ctrl = reg_wr && (reg_addr == crcc_pkg::ADDR_CONTROL_STATUS);
  assign wr_len = reg_wr && (reg_addr == crcc_pkg::ADDR_LENGTH_CONFIG);
  assign wr_dhi = reg_wr && (reg_addr == crcc_pkg::ADDR_INPUT_DATA_HIGH);
  assign wr_dlo = reg_wr && (reg_addr == crcc_pkg::ADDR_INPUT_DATA_LOW);
  assign wr_ahi = reg_wr && (reg_addr == crcc_pkg::ADDR_ACCUMULATOR_HIGH);
  assign wr_alo = reg_wr && (reg_addr == crcc_pkg::ADDR_ACCUMULATOR_LOW);
  assign wr_phi = reg_wr && (reg_addr == crcc_pkg::ADDR_POLY_HIGH);
  assign wr_plo = reg_wr && (reg_addr == crcc_pkg::ADDR_POLY_LOW);

  // control register: enable, start, augment, direction
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      // every writable field comes up cleared
      module_enable <= 1'b0;
      shifter_start <= 1'b0;
      augment_mode <= 1'b0;
      shift_direction <= 1'b0;
    end else if (wr_ctrl) begin
      // busy and full are status only, writes to them are ignored
      module_enable <= reg_wdata[crcc_pkg::BIT_MODULE_ENABLE];
      shifter_start <= reg_wdata[crcc_pkg::BIT_SHIFTER_START];
      augment_mode <= reg_wdata[crcc_pkg::BIT_AUGMENT_MODE];
      shift_direction <= reg_wdata[crcc_pkg::BIT_SHIFT_DIRECTION];
    end
  end

  // length register: data word and polynomial lengths
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      data_word_length <= crcc_pkg::RESET_LEN;
      poly_length <= crcc_pkg::RESET_LEN;
    end else if (wr_len) begin
      data_word_length <= reg_wdata[crcc_pkg::DATA_LEN_MSB:crcc_pkg::DATA_LEN_LSB];
      poly_length <= reg_wdata[crcc_pkg::POLY_LEN_MSB:crcc_pkg::POLY_LEN_LSB];
    end
  end

  // input data bytes as last written by software
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      input_data_high <= crcc_pkg::RESET_BYTE;
      input_data_low <= crcc_pkg::RESET_BYTE;
    end else begin
      if (wr_dhi) begin
        input_data_high <= reg_wdata;
      end
      if (wr_dlo) begin
        input_data_low <= reg_wdata;
      end
    end
  end

  // polynomial bytes; the top term is implied by poly_length
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      poly <= crcc_pkg::RESET_WORD;
    end else begin
      if (wr_phi) begin
        poly[15:8] <= reg_wdata;
      end
      if (wr_plo) begin
        poly[7:0] <= reg_wdata;
      end
    end
  end

  // a low-byte write queues the whole word; dropped while disabled or full
  assign push_if.valid = wr_dlo && module_enable;
  assign push_if.data = {input_data_high, reg_wdata};

  // word fifo between the register port and the shifter
  crcc_fifo #(
    .W(crcc_pkg::WORD_W),
    .D(crcc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .srst(srst),
    .flush(!module_enable),
    .in_p(push_if),
    .out_p(pop_if)
  );

  // the shifter takes a new word only when the last one is used up
  assign pop_if.ready = module_enable && shifter_start && (bits_left == 5'h00);
  assign load = pop_if.valid && pop_if.ready;
  // one bit per clock while enabled and started
  assign step = module_enable && shifter_start && (bits_left != 5'h00);

  // pick the outgoing bit from the end the direction names
  always_comb begin
    if (shift_direction) begin
      in_bit = shifter[0];
      next_shifter = shifter >> 1;
    end else begin
      in_bit = shifter[data_word_length];
      next_shifter = shifter << 1;
    end
  end

  // mask width follows poly_length; shorter polynomials ignore upper bits
  assign len_mask = crcc_pkg::ALL_ONES >> (crcc_pkg::MAX_LEN_M1 - poly_length);

  // one crc step; augmented mode feeds data through the accumulator
  always_comb begin
    next_acc = acc;
    feedback = 1'b0;
    if (shift_direction) begin
      // lsb-first, reflected polynomial
      feedback = augment_mode ? acc[0] : (acc[0] ^ in_bit);
      next_acc = acc >> 1;
      if (augment_mode) begin
        next_acc[poly_length] = in_bit;
      end
    end else begin
      // msb-first, top term sits just above poly_length
      feedback = augment_mode ? acc[poly_length] : (acc[poly_length] ^ in_bit);
      next_acc = acc << 1;
      if (augment_mode) begin
        next_acc[0] = in_bit;
      end
    end
    if (feedback) begin
      next_acc = next_acc ^ poly;
    end
    next_acc = next_acc & len_mask;
  end

  // shifter and bit counter; disabled engine is held empty
  always_ff @(posedge ref_clk) begin
    if (srst || !module_enable) begin
      shifter <= crcc_pkg::RESET_WORD;
      bits_left <= 5'h00;
    end else if (load) begin
      // word length is the field plus one
      shifter <= pop_if.data;
      bits_left <= {1'b0, data_word_length} + 5'h01;
    end else if (step) begin
      shifter <= next_shifter;
      bits_left <= bits_left - 5'h01;
    end
  end

  // accumulator: software write wins over an engine step in that cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      acc <= crcc_pkg::RESET_WORD;
    end else if (wr_ahi || wr_alo) begin
      // byte writes leave the other byte as it was
      if (wr_ahi) begin
        acc[15:8] <= reg_wdata;
      end
      if (wr_alo) begin
        acc[7:0] <= reg_wdata;
      end
    end else if (step) begin
      acc <= next_acc;
    end
  end

  // busy while the shifter holds bits or the fifo holds words
  assign busy = (bits_left != 5'h00) || pop_if.valid;
  // full once the fifo cannot take another word
  assign full = !push_if.ready;

  // read data, valid in the cycle after the read strobe
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= crcc_pkg::RESET_BYTE;
    end else if (reg_rd) begin
      unique case (reg_addr)
        crcc_pkg::ADDR_CONTROL_STATUS: begin
          // unimplemented bits 3-2 read zero
          reg_rdata <= crcc_pkg::RESET_BYTE;
          reg_rdata[crcc_pkg::BIT_MODULE_ENABLE] <= module_enable;
          reg_rdata[crcc_pkg::BIT_SHIFTER_START] <= shifter_start;
          reg_rdata[crcc_pkg::BIT_BUSY] <= busy;
          reg_rdata[crcc_pkg::BIT_AUGMENT_MODE] <= augment_mode;
          reg_rdata[crcc_pkg::BIT_SHIFT_DIRECTION] <= shift_direction;
          reg_rdata[crcc_pkg::BIT_FULL] <= full;
        end
        crcc_pkg::ADDR_LENGTH_CONFIG: begin
          reg_rdata <= {data_word_length, poly_length};
        end
        crcc_pkg::ADDR_INPUT_DATA_HIGH: begin
          reg_rdata <= input_data_high;
        end
        crcc_pkg::ADDR_INPUT_DATA_LOW: begin
          reg_rdata <= input_data_low;
        end
        crcc_pkg::ADDR_ACCUMULATOR_HIGH: begin
          reg_rdata <= acc[15:8];
        end
        crcc_pkg::ADDR_ACCUMULATOR_LOW: begin
          reg_rdata <= acc[7:0];
        end
        crcc_pkg::ADDR_SHIFTER_HIGH: begin
          reg_rdata <= shifter[15:8];
        end
        crcc_pkg::ADDR_SHIFTER_LOW: begin
          reg_rdata <= shifter[7:0];
        end
        crcc_pkg::ADDR_POLY_HIGH: begin
          reg_rdata <= poly[15:8];
        end
        crcc_pkg::ADDR_POLY_LOW: begin
          reg_rdata <= poly[7:0];
        end
        default: begin
          // unmapped index reads zero
          reg_rdata <= crcc_pkg::RESET_BYTE;
        end
      endcase
    end
  end
endmodule

// ===== crcc_pkg.sv
// constants shared by the crc control block and its word fifo
package crcc_pkg;
  // register indices on the byte-wide register port
  localparam logic [3:0] ADDR_CONTROL_STATUS = 4'h0;
  localparam logic [3:0] ADDR_LENGTH_CONFIG = 4'h1;
  localparam logic [3:0] ADDR_INPUT_DATA_HIGH = 4'h2;
  localparam logic [3:0] ADDR_INPUT_DATA_LOW = 4'h3;
  localparam logic [3:0] ADDR_ACCUMULATOR_HIGH = 4'h4;
  localparam logic [3:0] ADDR_ACCUMULATOR_LOW = 4'h5;
  localparam logic [3:0] ADDR_SHIFTER_HIGH = 4'h6;
  localparam logic [3:0] ADDR_SHIFTER_LOW = 4'h7;
  localparam logic [3:0] ADDR_POLY_HIGH = 4'h8;
  localparam logic [3:0] ADDR_POLY_LOW = 4'h9;

  // control/status field positions
  localparam int BIT_MODULE_ENABLE = 7;
  localparam int BIT_SHIFTER_START = 6;
  localparam int BIT_BUSY = 5;
  localparam int BIT_AUGMENT_MODE = 4;
  localparam int BIT_SHIFT_DIRECTION = 1;
  localparam int BIT_FULL = 0;

  // length config field positions
  localparam int DATA_LEN_MSB = 7;
  localparam int DATA_LEN_LSB = 4;
  localparam int POLY_LEN_MSB = 3;
  localparam int POLY_LEN_LSB = 0;

  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [3:0] RESET_LEN = 4'h0;

  // data path sizes
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] MAX_LEN_M1 = 4'hF;
  localparam logic [15:0] ALL_ONES = 16'hFFFF;
endpackage

// ===== crcc_word_if.sv
// valid/ready word channel between the crc control and its fifo
`timescale 1ns/100ps
interface crcc_word_if #(parameter int W = 16);
  logic valid; // word offered
  logic ready; // word accepted when both high
  logic [W-1:0] data; // the word
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ===== crcc_fifo.sv
// synchronous word fifo with valid/ready on both sides
`timescale 1ns/100ps
module crcc_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // drop every stored word
  input wire logic flush,
  // filling side
  crcc_word_if.snk in_p,
  // draining side
  crcc_word_if.src out_p
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D]; // word storage
  logic [AW-1:0] wr_ptr; // next slot to fill
  logic [AW-1:0] rd_ptr; // oldest word
  logic [AW:0] count; // words held
  logic push; // accepted write
  logic pop; // accepted read

  // honest full and empty flags
  assign in_p.ready = (count != D[AW:0]);
  assign out_p.valid = (count != '0);
  assign out_p.data = mem[rd_ptr];
  assign push = in_p.valid & in_p.ready;
  assign pop = out_p.valid & out_p.ready;

  // storage write, no reset needed on data
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_p.data;
    end
  end

  // pointers and fill count
  always_ff @(posedge ref_clk) begin
    if (srst || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ===== crcc_properties.sv
// port-level checker for the crc control block
`timescale 1ns/100ps
module crcc_properties (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // status
  input wire logic busy,
  input wire logic full
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic en_q; // mirror of the enable bit, so word queueing can be predicted
  // follow software writes of the enable bit
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      en_q <= 1'h0;
    end else if (reg_wr && reg_addr == crcc_pkg::ADDR_CONTROL_STATUS) begin
      en_q <= reg_wdata[crcc_pkg::BIT_MODULE_ENABLE];
    end
  end
  // write strobe and read strobe at one place
  sequence s_wr(logic [3:0] a);
    reg_wr && reg_addr == a;
  endsequence
  sequence s_rd(logic [3:0] a);
    reg_rd && reg_addr == a;
  endsequence
  // a write followed at once by a read returns the writable bits
  property p_readback(logic [3:0] a, logic [7:0] m);
    logic [7:0] v;
    (s_wr(a), v = reg_wdata) ##1 s_rd(a) |=> (reg_rdata & m) == (v & m);
  endproperty
  a_reset_clears: assert property ($fell(srst) |-> reg_rdata == 8'h00 && !busy && !full)
    else $error("outputs not clear after reset");
  a_full_busy: assert property (full |-> busy)
    else $error("full without busy");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_status_live: assert property (s_rd(crcc_pkg::ADDR_CONTROL_STATUS) |=>
    reg_rdata[crcc_pkg::BIT_BUSY] == $past(busy) && reg_rdata[crcc_pkg::BIT_FULL] == $past(full)
    && reg_rdata[3:2] == 2'h0)
    else $error("status byte does not match flags");
  a_ctrl_readback: assert property (p_readback(crcc_pkg::ADDR_CONTROL_STATUS, 8'hD2))
    else $error("control bits not kept");
  a_len_readback: assert property (p_readback(crcc_pkg::ADDR_LENGTH_CONFIG, 8'hFF))
    else $error("length fields not kept");
  a_disable_idle: assert property (s_wr(crcc_pkg::ADDR_CONTROL_STATUS) ##0 !reg_wdata[7]
    |-> ##2 !busy && !full)
    else $error("engine not idle after disable");
  a_word_busy: assert property (s_wr(crcc_pkg::ADDR_INPUT_DATA_LOW) ##0 (en_q && !full)
    |=> busy)
    else $error("queued word did not raise busy");
endmodule
bind crcc_top crcc_properties u_crcc_properties (.ref_clk(ref_clk), .srst(srst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .busy(busy), .full(full));

// ===== tb.sv
// self-checking bench for the crc control block
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  logic ref_clk = 1'h0, srst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, v, cw;
  logic [15:0] exp_acc;
  logic busy, full;
  int err_total = 0, tests_run = 0, n;
  // cases: length byte, polynomial, data word, augmented mode
  // the fourth case runs the right-shift direction with a reflected polynomial
  logic [7:0] c_len[5] = '{8'h77, 8'h77, 8'hFF, 8'h77, 8'h33};
  logic [15:0] c_poly[5] = '{16'h0007, 16'h0007, 16'h1021, 16'h00E0, 16'h0003};
  logic [15:0] c_dat[5] = '{16'h00A5, 16'h00A5, 16'h1234, 16'h00A5, 16'h000B};
  logic c_aug[5] = '{1'h0, 1'h1, 1'h0, 1'h0, 1'h1};
  logic c_dir[5] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h0};
  crcc_top u_crcc_top (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .busy(busy), .full(full));
  // 100 MHz system clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // write strobe left high so another access may follow with no gap
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_wr <= 1'h1;
    reg_rd <= 1'h0;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
  endtask
  // read data is held after the strobe, so it is taken one edge later
  task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
    reg_wr <= 1'h0;
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    @(posedge ref_clk);
    v = reg_rdata;
    `CHK(v, e)
  endtask
  // drop the write strobe and let edges pass
  task automatic idle(input int c);
    reg_wr <= 1'h0;
    repeat (c) @(posedge ref_clk);
  endtask
  // bounded wait for the engine to go quiet
  task automatic wait_idle();
    idle(1);
    for (int i = 0; i < 300 && busy !== 1'h0; i++) begin
      @(posedge ref_clk);
    end
  endtask
  // high byte first: the low byte write queues the whole word
  task automatic push(input logic [15:0] w);
    wr(crcc_pkg::ADDR_INPUT_DATA_HIGH, w[15:8]);
    wr(crcc_pkg::ADDR_INPUT_DATA_LOW, w[7:0]);
  endtask
  // all mapped places and one unmapped place read zero
  task automatic chk_zero();
    for (int a = 0; a < 11; a++) begin
      chk_rd(a == 10 ? 4'hF : 4'(a), 8'h00);
    end
  endtask
  // bit-serial reference in both directions, implied top term left out of poly
  function automatic logic [15:0] crc_ref(input logic [15:0] acc, input logic [15:0] poly,
      input logic [15:0] w, input logic [7:0] len, input logic aug, input logic dir);
    logic [15:0] m;
    logic fb;
    logic b;
    m = 16'hFFFF >> (4'hF - len[3:0]);
    for (int i = 0; i < 16; i++) begin
      if (i <= len[7:4]) begin
        // right shift takes the lsb first, left shift the top data bit first
        b = dir ? w[i] : w[len[7:4] - i];
        if (dir) begin
          fb = acc[0] ^ (aug ? 1'h0 : b);
          acc = acc >> 1;
          if (aug) begin
            acc[len[3:0]] = b;
          end
        end else begin
          fb = acc[len[3:0]] ^ (aug ? 1'h0 : b);
          acc = (acc << 1) | 16'(aug ? b : 1'h0);
        end
        acc = (acc & m) ^ ((fb ? poly : 16'h0000) & m);
      end
    end
    return acc;
  endfunction
  // verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // the tests need a few hundred cycles at most
  initial begin
    #50000;
    err_total++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    srst <= 1'h0;
    @(posedge ref_clk);
    chk_zero();
    $display("test reset done");
    wr(crcc_pkg::ADDR_CONTROL_STATUS, 8'hFF);
    chk_rd(crcc_pkg::ADDR_CONTROL_STATUS, 8'hD2);
    wr(crcc_pkg::ADDR_LENGTH_CONFIG, 8'hA5);
    chk_rd(crcc_pkg::ADDR_LENGTH_CONFIG, 8'hA5);
    wr(crcc_pkg::ADDR_SHIFTER_HIGH, 8'hFF);
    wr(4'hC, 8'hFF);
    chk_rd(crcc_pkg::ADDR_SHIFTER_HIGH, 8'h00);
    chk_rd(4'hC, 8'h00);
    wr(crcc_pkg::ADDR_CONTROL_STATUS, 8'h00);
    chk_rd(crcc_pkg::ADDR_CONTROL_STATUS, 8'h00);
    $display("test config done");
    for (int i = 0; i < 5; i++) begin
      cw = 8'h80 | {3'h0, c_aug[i], 2'h0, c_dir[i], 1'h0};
      wr(crcc_pkg::ADDR_CONTROL_STATUS, cw);
      wr(crcc_pkg::ADDR_LENGTH_CONFIG, c_len[i]);
      wr(crcc_pkg::ADDR_POLY_HIGH, c_poly[i][15:8]);
      wr(crcc_pkg::ADDR_POLY_LOW, c_poly[i][7:0]);
      wr(crcc_pkg::ADDR_ACCUMULATOR_HIGH, c_len[i]);
      wr(crcc_pkg::ADDR_ACCUMULATOR_LOW, c_len[i]);
      push(c_dat[i]);
      idle(10);
      `CHK(busy, 1'h1)
      wr(crcc_pkg::ADDR_CONTROL_STATUS, cw | 8'h40);
      wr(crcc_pkg::ADDR_CONTROL_STATUS, cw);
      idle(10);
      `CHK(busy, 1'h1)
      chk_rd(crcc_pkg::ADDR_SHIFTER_HIGH, c_dat[i][15:8]);
      chk_rd(crcc_pkg::ADDR_SHIFTER_LOW, c_dat[i][7:0]);
      wr(crcc_pkg::ADDR_CONTROL_STATUS, cw | 8'h40);
      wait_idle();
      `CHK(busy, 1'h0)
      exp_acc = crc_ref({c_len[i], c_len[i]}, c_poly[i], c_dat[i], c_len[i], c_aug[i],
        c_dir[i]);
      chk_rd(crcc_pkg::ADDR_ACCUMULATOR_HIGH, exp_acc[15:8]);
      chk_rd(crcc_pkg::ADDR_ACCUMULATOR_LOW, exp_acc[7:0]);
    end
    $display("test crc done");
    wr(crcc_pkg::ADDR_CONTROL_STATUS, 8'h80);
    n = 0;
    while (full !== 1'h1 && n < 12) begin
      push(16'(n));
      idle(1);
      n++;
    end
    `CHK(1'(n >= 8 && n <= 9), 1'h1)
    chk_rd(crcc_pkg::ADDR_CONTROL_STATUS, 8'hA1);
    push(16'hFFFF);
    wr(crcc_pkg::ADDR_CONTROL_STATUS, 8'hC0);
    wait_idle();
    `CHK({busy, full}, 2'h0)
    wr(crcc_pkg::ADDR_CONTROL_STATUS, 8'h80);
    push(16'h0001);
    push(16'h0002);
    wr(crcc_pkg::ADDR_CONTROL_STATUS, 8'h40);
    idle(2);
    `CHK({busy, full}, 2'h0)
    wr(crcc_pkg::ADDR_CONTROL_STATUS, 8'hC0);
    idle(3);
    `CHK(busy, 1'h0)
    $display("test fifo done");
    srst <= 1'h1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'h0;
    @(posedge ref_clk);
    chk_zero();
    $display("test second reset done");
    conclude();
  end
endmodule
